// File: io_queue_create_pkg.sv
package io_queue_create_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned QID_W = 16;
  localparam int unsigned QTAB_DEPTH = 64;
  localparam int unsigned QIDX_W = 6;
  localparam int unsigned CNT_W = 7;
  localparam int unsigned IRQ_W = 3;

  // ----------------------------------------
  // command kinds and fields
  // ----------------------------------------
  localparam logic KIND_SQ = 1'b0;
  localparam logic KIND_CQ = 1'b1;
  localparam int unsigned DW10_QSIZE_LSB = 16;
  localparam int unsigned DW10_QID_LSB = 0;
  localparam int unsigned DW11_CQID_LSB = 16;
  localparam int unsigned DW11_IV_LSB = 16;
  localparam int unsigned DW11_PRIO_LSB = 1;
  localparam int unsigned DW11_IEN_BIT = 1;
  localparam int unsigned DW11_PC_BIT = 0;
  localparam int unsigned PAGE_BASE_SHIFT = 12;

  // ----------------------------------------
  // completion status
  // ----------------------------------------
  localparam logic [2:0] SCT_GENERIC = 3'h0;
  localparam logic [2:0] SCT_CMD_SPECIFIC = 3'h1;
  localparam logic [7:0] SC_SUCCESS = 8'h00;
  localparam logic [7:0] SC_CQ_INVALID = 8'h00;
  localparam logic [7:0] SC_QID_INVALID = 8'h01;
  localparam logic [7:0] SC_QSIZE_EXCEEDED = 8'h02;
  localparam logic [7:0] SC_IV_INVALID = 8'h08;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MAX_ENTRIES = 8'h04;
  localparam logic [7:0] REG_QUEUE_LIMIT = 8'h08;
  localparam logic [7:0] REG_VECTORS = 8'h0C;
  localparam logic [7:0] REG_ASQ_LO = 8'h10;
  localparam logic [7:0] REG_ASQ_HI = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
  localparam logic [7:0] REG_LAST_STATUS = 8'h20;
  localparam logic [7:0] REG_QUEUE_USE = 8'h24;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_WRR_BIT = 1;
  localparam int unsigned CTRL_SINGLE_BIT = 2;
  localparam int unsigned CTRL_MPS_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] MAX_ENTRIES_RESET = 16'h003F;
  localparam logic [15:0] QUEUE_LIMIT_RESET = 16'h0000;
  localparam logic [11:0] VECTORS_RESET = 12'h001;

  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned IRQ_ERR_BIT = 1;
  localparam int unsigned IRQ_ASQ_BIT = 2;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CHECK = 2'b01,
    ST_POST = 2'b11
  } state_e;

endpackage : io_queue_create_pkg

// File: queue_id_table.sv
`timescale 1ns/100ps
module queue_id_table (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clearAll,
  input wire logic commit,
  input wire logic commitKind,
  input wire logic [io_queue_create_pkg::QIDX_W-1:0] commitIdx,
  input wire logic [io_queue_create_pkg::QIDX_W-1:0] sqLookup,
  input wire logic [io_queue_create_pkg::QIDX_W-1:0] cqLookup,
  output logic sqUsed,
  output logic cqUsed,
  output logic [io_queue_create_pkg::CNT_W-1:0] sqCount,
  output logic [io_queue_create_pkg::CNT_W-1:0] cqCount
);

  logic [io_queue_create_pkg::QTAB_DEPTH-1:0] sqMap_reg;
  logic [io_queue_create_pkg::QTAB_DEPTH-1:0] cqMap_reg;

  // ----------------------------------------
  // allocation bitmaps
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < io_queue_create_pkg::QTAB_DEPTH; i++) begin : gEntry
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sqMap_reg[i] <= 1'b0;
          cqMap_reg[i] <= 1'b0;
        end else if (clearAll) begin
          sqMap_reg[i] <= 1'b0;
          cqMap_reg[i] <= 1'b0;
        end else if (commit && int'(commitIdx) == i) begin
          if (commitKind == io_queue_create_pkg::KIND_SQ) begin
            sqMap_reg[i] <= 1'b1;
          end else begin
            cqMap_reg[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sqCount <= '0;
      cqCount <= '0;
    end else if (clearAll) begin
      sqCount <= '0;
      cqCount <= '0;
    end else if (commit) begin
      if (commitKind == io_queue_create_pkg::KIND_SQ) begin
        sqCount <= sqCount + 1'b1;
      end else begin
        cqCount <= cqCount + 1'b1;
      end
    end
  end

  assign sqUsed = sqMap_reg[sqLookup];
  assign cqUsed = cqMap_reg[cqLookup];

endmodule : queue_id_table

// File: event_irq.sv
`timescale 1ns/100ps
module event_irq (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [io_queue_create_pkg::IRQ_W-1:0] events,
  input wire logic clearWr,
  input wire logic maskWr,
  input wire logic [io_queue_create_pkg::IRQ_W-1:0] wdata,
  output logic [io_queue_create_pkg::IRQ_W-1:0] status,
  output logic [io_queue_create_pkg::IRQ_W-1:0] mask,
  output logic irq
);

  // set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~(clearWr ? wdata : '0)) | events;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask <= '0;
    end else if (maskWr) begin
      mask <= wdata;
    end
  end

  assign irq = |(status & mask);

endmodule : event_irq

// File: io_queue_create_validator.sv
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
// Contract
// [R1] post one completion status per creation command
// [R2] cq id in use or out of range: 1h
// [R3] cq size above max entries: 2h
// [R4] invalid cq interrupt vector: 8h
// [R5] admin sq comes from base register only
// [R6] host keeps page list fixed until deletion
// [R7] only first pointer, dword 10, 11 used
// [R8] pointer is base or list, page aligned
// [R9] host gives pointers with zero page offset
// [R10] entries equal queue size field plus one
// [R11] sq id selects tail doorbell, within limit
// [R12] dword 11 high half binds completion queue
// [R13] priority class used only under urgent wrr
// [R14] vector zero for single message, within count
// [R15] sq naming missing cq: status 0h
// [R16] sq size above max entries: 2h
// [R17] rejected commands leave queue state untouched
// [R18] all checks before commit, one status
module io_queue_create_validator (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdKind,
  input wire logic [63:0] cmdPrp1,
  input wire logic [31:0] cmdDw10,
  input wire logic [31:0] cmdDw11,
  output logic cplValid,
  input wire logic cplReady,
  output logic [2:0] cplStatusType,
  output logic [7:0] cplStatusCode,
  output logic [15:0] cplQueueId,
  output logic createValid,
  output logic createKind,
  output logic [63:0] createBase,
  output logic createIsList,
  output logic [16:0] createEntries,
  output logic [15:0] createQueueId,
  output logic [15:0] createCqId,
  output logic [1:0] createPrio,
  output logic createPrioUsed,
  output logic [15:0] createVector,
  output logic createIntEn,
  output logic [63:0] adminSqBase,
  output logic adminSqLoad,
  output logic irq
);

  // ----------------------------------------
  // types and helpers
  // ----------------------------------------
  io_queue_create_pkg::state_e state_reg;
  io_queue_create_pkg::state_e state_next;

  function automatic logic [10:0] makeStatus(input logic [2:0] sct, input logic [7:0] sc);
    makeStatus = {sct, sc};
  endfunction : makeStatus

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] ctrl_reg;
  logic [15:0] maxEntries_reg;
  logic [15:0] sqLimit_reg;
  logic [15:0] cqLimit_reg;
  logic [11:0] vectors_reg;
  logic [31:0] asqLo_reg;
  logic [10:0] lastStatus_reg;
  logic [15:0] lastQid_reg;
  logic kind_reg;
  logic [63:0] prp1_reg;
  logic [31:0] dw10_reg;
  logic [31:0] dw11_reg;
  logic [10:0] status_reg;
  logic [10:0] status_next;
  logic ctrlEn;
  logic wrrUrgent;
  logic singleMsg;
  logic [3:0] mps;
  logic [io_queue_create_pkg::IRQ_W-1:0] irqStatus;
  logic [io_queue_create_pkg::IRQ_W-1:0] irqMask;
  logic [io_queue_create_pkg::IRQ_W-1:0] irqEvents;
  logic [io_queue_create_pkg::CNT_W-1:0] sqCount;
  logic [io_queue_create_pkg::CNT_W-1:0] cqCount;
  logic sqUsed;
  logic cqUsed;
  logic commit;
  logic cmdTake;
  logic cplDone;
  logic wrAsqHi;

  assign ctrlEn = ctrl_reg[io_queue_create_pkg::CTRL_EN_BIT];
  assign wrrUrgent = ctrl_reg[io_queue_create_pkg::CTRL_WRR_BIT];
  assign singleMsg = ctrl_reg[io_queue_create_pkg::CTRL_SINGLE_BIT];
  assign mps = ctrl_reg[io_queue_create_pkg::CTRL_MPS_LSB +: 4];
  assign wrAsqHi = regWr && regAddr == io_queue_create_pkg::REG_ASQ_HI;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= io_queue_create_pkg::CTRL_RESET;
      maxEntries_reg <= io_queue_create_pkg::MAX_ENTRIES_RESET;
      sqLimit_reg <= io_queue_create_pkg::QUEUE_LIMIT_RESET;
      cqLimit_reg <= io_queue_create_pkg::QUEUE_LIMIT_RESET;
      vectors_reg <= io_queue_create_pkg::VECTORS_RESET;
      asqLo_reg <= '0;
    end else if (regWr) begin
      unique case (regAddr)
        io_queue_create_pkg::REG_CTRL: ctrl_reg <= regWdata & 32'h0000_00F7;
        io_queue_create_pkg::REG_MAX_ENTRIES: maxEntries_reg <= regWdata[15:0];
        io_queue_create_pkg::REG_QUEUE_LIMIT: begin
          sqLimit_reg <= regWdata[15:0];
          cqLimit_reg <= regWdata[31:16];
        end
        io_queue_create_pkg::REG_VECTORS: vectors_reg <= regWdata[11:0];
        io_queue_create_pkg::REG_ASQ_LO: asqLo_reg <= regWdata;
        default: ;
      endcase
    end
  end

  // admin sq is loaded from the base register pair, never by a command
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adminSqBase <= '0;
      adminSqLoad <= 1'b0;
    end else begin
      adminSqLoad <= wrAsqHi; // [R5]
      if (wrAsqHi) begin
        adminSqBase <= {regWdata, asqLo_reg}; // [R5]
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        io_queue_create_pkg::REG_CTRL: regRdata <= ctrl_reg;
        io_queue_create_pkg::REG_MAX_ENTRIES: regRdata <= {16'h0000, maxEntries_reg};
        io_queue_create_pkg::REG_QUEUE_LIMIT: regRdata <= {cqLimit_reg, sqLimit_reg};
        io_queue_create_pkg::REG_VECTORS: regRdata <= {20'h00000, vectors_reg};
        io_queue_create_pkg::REG_ASQ_LO: regRdata <= asqLo_reg;
        io_queue_create_pkg::REG_ASQ_HI: regRdata <= adminSqBase[63:32];
        io_queue_create_pkg::REG_IRQ_STAT: regRdata <= {29'h0, irqStatus};
        io_queue_create_pkg::REG_IRQ_MASK: regRdata <= {29'h0, irqMask};
        io_queue_create_pkg::REG_LAST_STATUS: regRdata <= {lastQid_reg, 5'h00, lastStatus_reg};
        io_queue_create_pkg::REG_QUEUE_USE: regRdata <= {9'h000, cqCount, 9'h000, sqCount};
        default: regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ----------------------------------------
  // command capture
  // ----------------------------------------
  assign cmdReady = state_reg == io_queue_create_pkg::ST_IDLE;
  assign cmdTake = cmdValid && cmdReady;
  assign cplDone = cplValid && cplReady;

  // only the kind, the pointer and dwords 10 and 11 are held; the rest is reserved
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      kind_reg <= io_queue_create_pkg::KIND_SQ;
      prp1_reg <= '0;
      dw10_reg <= '0;
      dw11_reg <= '0;
    end else if (cmdTake) begin
      kind_reg <= cmdKind;
      prp1_reg <= cmdPrp1; // [R7]
      dw10_reg <= cmdDw10; // [R7]
      dw11_reg <= cmdDw11; // [R7]
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  logic [15:0] qSize;
  logic [15:0] qid;
  logic [15:0] cqBind;
  logic [15:0] vector;
  logic [15:0] idLimit;
  logic qidBad;
  logic sizeBad;
  logic cqBad;
  logic vectorBad;
  logic [63:0] pageMask;

  assign qSize = dw10_reg[io_queue_create_pkg::DW10_QSIZE_LSB +: 16];
  assign qid = dw10_reg[io_queue_create_pkg::DW10_QID_LSB +: 16];
  assign cqBind = dw11_reg[io_queue_create_pkg::DW11_CQID_LSB +: 16]; // [R12]
  assign vector = dw11_reg[io_queue_create_pkg::DW11_IV_LSB +: 16]; // [R14]
  assign idLimit = (kind_reg == io_queue_create_pkg::KIND_SQ) ? sqLimit_reg : cqLimit_reg;

  // id 0 is the admin queue, so a command may never claim it
  assign qidBad = qid == 16'h0000 || qid > idLimit || // [R2] [R11] [R5]
    qid >= 16'(io_queue_create_pkg::QTAB_DEPTH) ||
    ((kind_reg == io_queue_create_pkg::KIND_SQ) ? sqUsed : cqUsed);
  // both sides zero based, so compare fields directly
  assign sizeBad = qSize > maxEntries_reg; // [R3] [R16] [R10]
  assign cqBad = cqBind == 16'h0000 || cqBind >= 16'(io_queue_create_pkg::QTAB_DEPTH) ||
    !cqUsed; // [R15]
  assign vectorBad = (singleMsg && vector != 16'h0000) || // [R4] [R14]
    vector >= {4'h0, vectors_reg};

  // fixed order gives one status even when several checks fail
  always_comb begin
    status_next = makeStatus(io_queue_create_pkg::SCT_GENERIC, io_queue_create_pkg::SC_SUCCESS);
    if (qidBad) begin
      status_next = makeStatus(io_queue_create_pkg::SCT_CMD_SPECIFIC,
        io_queue_create_pkg::SC_QID_INVALID); // [R18] [R2]
    end else if (sizeBad) begin
      status_next = makeStatus(io_queue_create_pkg::SCT_CMD_SPECIFIC,
        io_queue_create_pkg::SC_QSIZE_EXCEEDED); // [R3] [R16]
    end else if (kind_reg == io_queue_create_pkg::KIND_SQ && cqBad) begin
      status_next = makeStatus(io_queue_create_pkg::SCT_CMD_SPECIFIC,
        io_queue_create_pkg::SC_CQ_INVALID); // [R15]
    end else if (kind_reg == io_queue_create_pkg::KIND_CQ && vectorBad) begin
      status_next = makeStatus(io_queue_create_pkg::SCT_CMD_SPECIFIC,
        io_queue_create_pkg::SC_IV_INVALID); // [R4]
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      io_queue_create_pkg::ST_IDLE: if (cmdTake) state_next = io_queue_create_pkg::ST_CHECK;
      io_queue_create_pkg::ST_CHECK: state_next = io_queue_create_pkg::ST_POST;
      io_queue_create_pkg::ST_POST: if (cplDone) state_next = io_queue_create_pkg::ST_IDLE;
      default: state_next = io_queue_create_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= io_queue_create_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign commit = state_reg == io_queue_create_pkg::ST_CHECK &&
    status_next[7:0] == io_queue_create_pkg::SC_SUCCESS &&
    status_next[10:8] == io_queue_create_pkg::SCT_GENERIC; // [R17] [R18]

  queue_id_table uTable (
    .clk(clk),
    .arst_n(arst_n),
    .clearAll(!ctrlEn),
    .commit(commit),
    .commitKind(kind_reg),
    .commitIdx(qid[io_queue_create_pkg::QIDX_W-1:0]),
    .sqLookup(qid[io_queue_create_pkg::QIDX_W-1:0]),
    .cqLookup((kind_reg == io_queue_create_pkg::KIND_SQ) ?
      cqBind[io_queue_create_pkg::QIDX_W-1:0] : qid[io_queue_create_pkg::QIDX_W-1:0]),
    .sqUsed(sqUsed),
    .cqUsed(cqUsed),
    .sqCount(sqCount),
    .cqCount(cqCount)
  );

  // ----------------------------------------
  // completion posting
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= '0;
      cplValid <= 1'b0;
      lastStatus_reg <= '0;
      lastQid_reg <= '0;
    end else if (state_reg == io_queue_create_pkg::ST_CHECK) begin
      status_reg <= status_next;
      cplValid <= 1'b1; // [R1]
      lastStatus_reg <= status_next;
      lastQid_reg <= qid;
    end else if (cplDone) begin
      cplValid <= 1'b0;
    end
  end

  assign cplStatusType = status_reg[10:8];
  assign cplStatusCode = status_reg[7:0];
  assign cplQueueId = lastQid_reg;

  // ----------------------------------------
  // queue creation output
  // ----------------------------------------
  assign pageMask = (64'h1 << (io_queue_create_pkg::PAGE_BASE_SHIFT + mps)) - 64'h1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      createValid <= 1'b0;
      createKind <= io_queue_create_pkg::KIND_SQ;
      createBase <= '0;
      createIsList <= 1'b0;
      createEntries <= '0;
      createQueueId <= '0;
      createCqId <= '0;
      createPrio <= '0;
      createPrioUsed <= 1'b0;
      createVector <= '0;
      createIntEn <= 1'b0;
    end else begin
      createValid <= commit; // [R17]
      if (commit) begin
        createKind <= kind_reg;
        // offset bits dropped; host keeps them zero and the list stable
        createBase <= prp1_reg & ~pageMask; // [R8] [R9] [R6]
        createIsList <= !dw11_reg[io_queue_create_pkg::DW11_PC_BIT]; // [R8]
        createEntries <= {1'b0, qSize} + 17'h00001; // [R10]
        createQueueId <= qid; // [R11]
        createCqId <= (kind_reg == io_queue_create_pkg::KIND_SQ) ? cqBind : 16'h0000; // [R12]
        createPrio <= dw11_reg[io_queue_create_pkg::DW11_PRIO_LSB +: 2]; // [R13]
        createPrioUsed <= wrrUrgent && kind_reg == io_queue_create_pkg::KIND_SQ; // [R13]
        createVector <= (kind_reg == io_queue_create_pkg::KIND_CQ) ? vector : 16'h0000; // [R14]
        createIntEn <= kind_reg == io_queue_create_pkg::KIND_CQ &&
          dw11_reg[io_queue_create_pkg::DW11_IEN_BIT];
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  assign irqEvents[io_queue_create_pkg::IRQ_DONE_BIT] = commit;
  assign irqEvents[io_queue_create_pkg::IRQ_ERR_BIT] =
    state_reg == io_queue_create_pkg::ST_CHECK && !commit;
  assign irqEvents[io_queue_create_pkg::IRQ_ASQ_BIT] = wrAsqHi;

  event_irq uIrq (
    .clk(clk),
    .arst_n(arst_n),
    .events(irqEvents),
    .clearWr(regWr && regAddr == io_queue_create_pkg::REG_IRQ_STAT),
    .maskWr(regWr && regAddr == io_queue_create_pkg::REG_IRQ_MASK),
    .wdata(regWdata[io_queue_create_pkg::IRQ_W-1:0]),
    .status(irqStatus),
    .mask(irqMask),
    .irq(irq)
  );

endmodule : io_queue_create_validator

// File: io_queue_create_chk.sv
`timescale 1ns/100ps
module io_queue_create_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic regWr,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [31:0] cmdDw10,
  input wire logic [31:0] cmdDw11,
  input wire logic cplValid,
  input wire logic cplReady,
  input wire logic [2:0] cplStatusType,
  input wire logic [7:0] cplStatusCode,
  input wire logic createValid,
  input wire logic createKind,
  input wire logic [16:0] createEntries,
  input wire logic [15:0] createQueueId,
  input wire logic [15:0] createCqId,
  input wire logic createPrioUsed,
  input wire logic adminSqLoad
);
  // ----------------------------------------
  // command fields seen at the take edge
  // ----------------------------------------
  logic [15:0] qszReg;
  logic [15:0] qidReg;
  logic [15:0] cqReg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      qszReg <= 16'h0;
      qidReg <= 16'h0;
      cqReg <= 16'h0;
    end else if (cmdValid && cmdReady) begin
      qszReg <= cmdDw10[31:16];
      qidReg <= cmdDw10[15:0];
      cqReg <= cmdDw11[31:16];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_CPL_LAT: assert property (cmdValid && cmdReady |-> ##2 cplValid)
    else $error("completion not posted two cycles after take");
  AST_BUSY: assert property (cmdValid && cmdReady |=> !cmdReady [*2])
    else $error("second command taken while one is open");
  AST_CPL_HOLD: assert property (cplValid && !cplReady |=>
    cplValid && $stable(cplStatusCode))
    else $error("completion dropped or changed before accept");
  AST_CREATE_OK: assert property (createValid |-> cplValid && cplStatusCode == 8'h00
    && cplStatusType == io_queue_create_pkg::SCT_GENERIC)
    else $error("queue created on a failing status");
  AST_ERR_NONE: assert property (cplValid && cplStatusType != 3'h0 |-> !createValid)
    else $error("create pulse beside an error status");
  AST_ONE_PULSE: assert property (createValid |=> !createValid)
    else $error("create pulse longer than one cycle");
  AST_ENTRIES: assert property (createValid |-> createEntries == {1'b0, qszReg} + 17'h1)
    else $error("entry count is not size plus one");
  AST_QID: assert property (createValid |-> createQueueId == qidReg)
    else $error("created queue id differs from command");
  AST_CQID: assert property (createValid && !createKind |-> createCqId == cqReg)
    else $error("bound completion queue differs from command");
  AST_PRIO: assert property (createValid && createKind |-> !createPrioUsed)
    else $error("priority class used on a completion queue");
  AST_ASQ: assert property (regWr && regAddr == 8'h14 |=> adminSqLoad)
    else $error("admin queue base not loaded after high write");
  cover property (createValid && createKind);
  cover property (cplValid && cplStatusCode == 8'h08);
  cover property (adminSqLoad);
endmodule : io_queue_create_chk
bind io_queue_create_validator io_queue_create_chk chk_u (.*);

// File: host_cmd_model.sv
`timescale 1ns/100ps
module host_cmd_model (
  input wire logic clk,
  output logic cmdValid,
  input wire logic cmdReady,
  output logic cmdKind,
  output logic [63:0] cmdPrp1,
  output logic [31:0] cmdDw10,
  output logic [31:0] cmdDw11,
  input wire logic cplValid,
  output logic cplReady,
  input wire logic [2:0] cplStatusType,
  input wire logic [7:0] cplStatusCode,
  input wire logic createValid
);
  initial begin
    cmdValid = 1'h0;
    cplReady = 1'h0;
    cmdKind = 1'h0;
    cmdPrp1 = 64'h0;
    cmdDw10 = 32'h0;
    cmdDw11 = 32'h0;
  end
  task automatic send(input logic k, input logic [63:0] p, input logic [31:0] d10,
    input logic [31:0] d11, input int stall, output logic [2:0] st, output logic [7:0] sc,
    output logic cv);
    int n;
    n = 0;
    cmdValid <= 1'h1;
    cmdKind <= k;
    cmdPrp1 <= p & ~64'hFFF;
    cmdDw10 <= d10;
    cmdDw11 <= d11;
    @(posedge clk);
    while (!cmdReady && n < 100) begin
      n++;
      @(posedge clk);
    end
    // released fields must not keep the old command
    cmdValid <= 1'h0;
    cmdKind <= ~k;
    cmdPrp1 <= ~p;
    cmdDw10 <= ~d10;
    cmdDw11 <= ~d11;
    do begin
      @(posedge clk);
      n++;
    end while (!cplValid && n < 100);
    cv = createValid;
    repeat (stall) @(posedge clk);
    cplReady <= 1'h1;
    @(posedge clk);
    st = cplStatusType;
    sc = cplStatusCode;
    cplReady <= 1'h0;
  endtask : send
endmodule : host_cmd_model

// File: io_queue_create_validator_tb.sv
`timescale 1ns/100ps
module io_queue_create_validator_tb;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic [7:0] regAddr = 8'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic [31:0] regRdata;
  logic cmdValid, cmdReady, cmdKind, cplValid, cplReady, createValid, createKind;
  logic createIsList, createPrioUsed, createIntEn, adminSqLoad, irq, wrr;
  logic [63:0] cmdPrp1, createBase, adminSqBase;
  logic [31:0] cmdDw10, cmdDw11;
  logic [2:0] cplStatusType;
  logic [7:0] cplStatusCode;
  logic [15:0] cplQueueId, createQueueId, createCqId, createVector;
  logic [16:0] createEntries;
  logic [1:0] createPrio;
  int num_errors = 0;
  int num_checks = 0;
  int seed = 48;
  always #4 clk = ~clk;
  io_queue_create_validator dut_u (.*);
  host_cmd_model host_u (.*);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [10:0] expStat(input logic [7:0] sc, input logic ok);
    return ok ? 11'h0 : {3'h1, sc};
  endfunction : expStat
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    @(posedge clk);
    chk(what, {32'h0, exp}, {32'h0, regRdata});
  endtask : rd
  task automatic cmd(input logic k, input logic [15:0] qid, input logic [15:0] qsz,
    input logic [15:0] hi, input logic [2:0] lo, input logic [7:0] sc, input logic ok);
    logic [63:0] p;
    logic [2:0] st;
    logic [7:0] c;
    logic cv;
    p = {$random(seed), $random(seed)};
    p[11:0] = 12'h0;
    host_u.send(k, p, {qsz, qid}, {hi, 13'h0, lo}, {$random(seed)} % 4, st, c, cv);
    chk("status", {53'h0, expStat(sc, ok)}, {53'h0, st, c});
    chk("cplQid", {48'h0, qid}, {48'h0, cplQueueId});
    chk("created", {63'h0, ok}, {63'h0, cv});
    if (ok) begin
      chk("kind", {63'h0, k}, {63'h0, createKind});
      chk("entries", {47'h0, qsz} + 64'h1, {47'h0, createEntries});
      chk("qid", {48'h0, qid}, {48'h0, createQueueId});
      chk("base", p, createBase);
      chk("isList", {63'h0, !lo[0]}, {63'h0, createIsList});
      chk("cqId", k ? 64'h0 : {48'h0, hi}, {48'h0, createCqId});
      chk("vector", k ? {48'h0, hi} : 64'h0, {48'h0, createVector});
      chk("prio", {62'h0, lo[2:1]}, {62'h0, createPrio});
      chk("prioUsed", {63'h0, wrr && !k}, {63'h0, createPrioUsed});
      chk("intEn", {63'h0, k && lo[1]}, {63'h0, createIntEn});
    end
  endtask : cmd
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    wrr = 1'h1;
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    rd(8'h04, 32'h3F, "maxEntries");
    rd(8'h0C, 32'h1, "vectors");
    rd(8'hFC, 32'h0, "unmapped");
    wr(8'h00, 32'h3);
    wr(8'h08, 32'h0008_0008);
    wr(8'h1C, 32'h7);
    cmd(1'h1, 16'h1, 16'h3F, 16'h0, 3'h3, 8'h0, 1'h1);
    cmd(1'h1, 16'h1, 16'h1, 16'h0, 3'h1, 8'h01, 1'h0);
    cmd(1'h1, 16'h9, 16'h1, 16'h0, 3'h1, 8'h01, 1'h0);
    cmd(1'h1, 16'h2, 16'h40, 16'h0, 3'h1, 8'h02, 1'h0);
    cmd(1'h1, 16'h2, 16'h0, 16'h1, 3'h1, 8'h08, 1'h0);
    cmd(1'h0, 16'h1, 16'h10, 16'h1, 3'h4, 8'h0, 1'h1);
    cmd(1'h0, 16'h2, 16'h10, 16'h5, 3'h1, 8'h00, 1'h0);
    cmd(1'h0, 16'h2, 16'h40, 16'h1, 3'h1, 8'h02, 1'h0);
    cmd(1'h0, 16'h0, 16'h1, 16'h1, 3'h1, 8'h01, 1'h0);
    cmd(1'h0, 16'h1, 16'h40, 16'h5, 3'h1, 8'h01, 1'h0);
    rd(8'h24, 32'h0001_0001, "queueUse");
    for (int i = 2; i < 8; i++) begin
      cmd(1'h0, 16'(i), 16'({$random(seed)} % 64), 16'h1, 3'($random(seed)), 8'h0, 1'h1);
    end
    rd(8'h24, 32'h0001_0007, "queueUse");
    wrr = 1'h0;
    wr(8'h00, 32'h1);
    cmd(1'h0, 16'h8, 16'h2, 16'h1, 3'h3, 8'h0, 1'h1);
    rd(8'h20, 32'h0008_0000, "lastStatus");
    rd(8'h18, 32'h3, "irqStat");
    chk("irq", 64'h1, {63'h0, irq});
    wr(8'h1C, 32'h0);
    chk("irq", 64'h0, {63'h0, irq});
    wr(8'h18, 32'h3);
    rd(8'h18, 32'h0, "irqStat");
    wr(8'h0C, 32'h4);
    cmd(1'h1, 16'h3, 16'h7, 16'h3, 3'h3, 8'h0, 1'h1);
    wr(8'h00, 32'h5);
    cmd(1'h1, 16'h4, 16'h7, 16'h1, 3'h1, 8'h08, 1'h0);
    wr(8'h10, 32'h1234_5000);
    wr(8'h14, 32'h0000_00AB);
    chk("adminBase", 64'h0000_00AB_1234_5000, adminSqBase);
    give_verdict();
  end
endmodule : io_queue_create_validator_tb
